// File: src/atsc_ctrl.sv
`timescale 1ns/1ps
`include "atsc_regs.svh"

module atsc_ctrl (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire atsc_pkg::atsc_bus_t bus,
   output logic [31:0] rdata_r,
   input wire logic [15:0] inj_trig_in,
   input wire logic [15:0] reg_trig_in,
   input wire atsc_pkg::atsc_core_t core,
   input wire atsc_pkg::atsc_result_t result,
   input wire logic [4:0] sample_channel,
   output logic converter_enable_r,
   output logic reg_start_r,
   output logic inj_start_r,
   output logic conversion_done_flag_r,
   output logic [15:0] result_word_r,
   output logic [8:0] sample_cycles_r
);
   import atsc_pkg::*;

   logic [31:0] ctrl_r;
   logic [31:0] smp_low_r;
   logic [31:0] smp_high_r;
   logic regular_software_start_r;
   logic injected_software_start_r;
   logic [15:0] inj_meta_r;
   logic [15:0] inj_sync_r;
   logic [15:0] reg_meta_r;
   logic [15:0] reg_sync_r;
   logic inj_lvl_r;
   logic reg_lvl_r;

   logic wr_ctrl;
   logic wr_status;
   logic reg_sw_set;
   logic inj_sw_set;
   logic [3:0] regular_trigger_source;
   logic [3:0] injected_trigger_source;
   atsc_edge_t regular_trigger_edge;
   atsc_edge_t injected_trigger_edge;
   logic conversion_done_select;
   logic result_alignment;
   logic converter_enable;
   logic inj_sel;
   logic reg_sel;
   logic inj_hit;
   logic reg_hit;
   logic done_set;
   logic [2:0] code_c;
   logic [31:0] rd_c;

   assign converter_enable = ctrl_r[`ATSC_EN_BIT];
   assign conversion_done_select = ctrl_r[`ATSC_DONE_SEL_BIT];
   assign result_alignment = ctrl_r[`ATSC_ALIGN_BIT];
   assign injected_trigger_source =
      ctrl_r[`ATSC_INJ_SRC_LSB +: 4];
   assign injected_trigger_edge =
      ctrl_r[`ATSC_INJ_EDGE_LSB +: 2];
   assign regular_trigger_source =
      ctrl_r[`ATSC_REG_SRC_LSB +: 4];
   assign regular_trigger_edge =
      ctrl_r[`ATSC_REG_EDGE_LSB +: 2];

   assign wr_ctrl = bus.wr && (bus.addr == `ATSC_CTRL2_OFS);
   assign wr_status = bus.wr && (bus.addr == `ATSC_STATUS_OFS);

   // Start is accepted only with the converter enabled
   assign reg_sw_set = wr_ctrl && bus.wdata[`ATSC_REG_SW_BIT] &&
      bus.wdata[`ATSC_EN_BIT];
   assign inj_sw_set = wr_ctrl && bus.wdata[`ATSC_INJ_SW_BIT] &&
      bus.wdata[`ATSC_EN_BIT];

   // Control register, start bits kept apart
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r <= `ATSC_CTRL_RST;
      end else if (ce && wr_ctrl) begin
         ctrl_r <= bus.wdata & `ATSC_CTRL_MASK;
      end
   end

   // Sample time registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         smp_low_r <= `ATSC_SMP_RST;
         smp_high_r <= `ATSC_SMP_RST;
      end else if (ce && bus.wr) begin
         if (bus.addr == `ATSC_SMP_LOW_OFS) begin
            smp_low_r <= bus.wdata & `ATSC_SMP_LOW_MASK;
         end
         if (bus.addr == `ATSC_SMP_HIGH_OFS) begin
            smp_high_r <= bus.wdata & `ATSC_SMP_HIGH_MASK;
         end
      end
   end

   // Software start bits, a new write wins over the clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         regular_software_start_r <= 1'h0;
         injected_software_start_r <= 1'h0;
      end else if (ce) begin
         if (reg_sw_set) begin
            regular_software_start_r <= 1'h1;
         end else if (core.reg_begun) begin
            regular_software_start_r <= 1'h0;
         end
         if (inj_sw_set) begin
            injected_software_start_r <= 1'h1;
         end else if (core.inj_begun) begin
            injected_software_start_r <= 1'h0;
         end
      end
   end

   // Two-stage synchronisers per trigger line
   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1) begin : g_sync
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               inj_meta_r[i] <= 1'h0;
               inj_sync_r[i] <= 1'h0;
               reg_meta_r[i] <= 1'h0;
               reg_sync_r[i] <= 1'h0;
            end else if (ce) begin
               inj_meta_r[i] <= inj_trig_in[i];
               inj_sync_r[i] <= inj_meta_r[i];
               reg_meta_r[i] <= reg_trig_in[i];
               reg_sync_r[i] <= reg_meta_r[i];
            end
         end
      end
   endgenerate

   // Source select, code 15 is an interrupt line
   assign inj_sel = inj_sync_r[injected_trigger_source];
   assign reg_sel = reg_sync_r[regular_trigger_source];

   // Edge qualification
   assign inj_hit = (injected_trigger_edge[0] && inj_sel &&
      !inj_lvl_r) || (injected_trigger_edge[1] && !inj_sel &&
      inj_lvl_r);
   assign reg_hit = (regular_trigger_edge[0] && reg_sel &&
      !reg_lvl_r) || (regular_trigger_edge[1] && !reg_sel &&
      reg_lvl_r);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         inj_lvl_r <= 1'h0;
         reg_lvl_r <= 1'h0;
      end else if (ce) begin
         inj_lvl_r <= inj_sel;
         reg_lvl_r <= reg_sel;
      end
   end

   // Single-cycle start pulses to the core
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_start_r <= 1'h0;
         inj_start_r <= 1'h0;
      end else if (ce) begin
         reg_start_r <= converter_enable &&
            (reg_hit || reg_sw_set);
         inj_start_r <= converter_enable &&
            (inj_hit || inj_sw_set);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         converter_enable_r <= 1'h0;
      end else if (ce) begin
         converter_enable_r <= wr_ctrl ?
            bus.wdata[`ATSC_EN_BIT] : converter_enable;
      end
   end

   // End-of-conversion flag, set wins over software clear
   assign done_set = converter_enable && (conversion_done_select ?
      core.conv_done : core.seq_done);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         conversion_done_flag_r <= 1'h0;
      end else if (ce) begin
         if (done_set) begin
            conversion_done_flag_r <= 1'h1;
         end else if (wr_status &&
               !bus.wdata[`ATSC_DONE_FLAG_BIT]) begin
            conversion_done_flag_r <= 1'h0;
         end
      end
   end

   // Result alignment
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         result_word_r <= 16'h0000;
      end else if (ce && result.valid) begin
         if (result_alignment) begin
            result_word_r <= {result.data, 4'h0};
         end else begin
            result_word_r <= {4'h0, result.data};
         end
      end
   end

   // Sample time field of the chosen channel
   always_comb begin
      code_c = 3'h0;
      if (sample_channel < 5'h09) begin
         code_c = smp_low_r[sample_channel * 3 +: 3];
      end else if (sample_channel < 5'h13) begin
         code_c = smp_high_r[(sample_channel - 5'h09) * 3 +: 3];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sample_cycles_r <= `ATSC_SMP_CYC_0;
      end else if (ce) begin
         case (code_c)
            3'h0: sample_cycles_r <= `ATSC_SMP_CYC_0;
            3'h1: sample_cycles_r <= `ATSC_SMP_CYC_1;
            3'h2: sample_cycles_r <= `ATSC_SMP_CYC_2;
            3'h3: sample_cycles_r <= `ATSC_SMP_CYC_3;
            3'h4: sample_cycles_r <= `ATSC_SMP_CYC_4;
            3'h5: sample_cycles_r <= `ATSC_SMP_CYC_5;
            3'h6: sample_cycles_r <= `ATSC_SMP_CYC_6;
            default: sample_cycles_r <= `ATSC_SMP_CYC_7;
         endcase
      end
   end

   // Read mux, unmapped reads return zero
   always_comb begin
      rd_c = 32'h0000_0000;
      case (bus.addr)
         `ATSC_STATUS_OFS: begin
            rd_c[`ATSC_DONE_FLAG_BIT] = conversion_done_flag_r;
         end
         `ATSC_CTRL2_OFS: begin
            rd_c = ctrl_r;
            rd_c[`ATSC_REG_SW_BIT] = regular_software_start_r;
            rd_c[`ATSC_INJ_SW_BIT] = injected_software_start_r;
         end
         `ATSC_SMP_LOW_OFS: rd_c = smp_low_r;
         `ATSC_SMP_HIGH_OFS: rd_c = smp_high_r;
         `ATSC_RESULT_OFS: rd_c = {16'h0000, result_word_r};
         default: rd_c = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= 32'h0000_0000;
      end else if (ce && bus.rd) begin
         rdata_r <= rd_c;
      end
   end

   // Checks
   a_done_seq_mode: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && converter_enable && !conversion_done_select &&
      core.seq_done |=> conversion_done_flag_r)
      else $error("done flag missed sequence end");

   a_done_each_conv: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && !conversion_done_flag_r && !conversion_done_select &&
      core.conv_done && !core.seq_done && !wr_status
      |=> !conversion_done_flag_r)
      else $error("done flag set mid sequence");

   a_align_left: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && result.valid && result_alignment
      |=> result_word_r == {$past(result.data), 4'h0})
      else $error("left alignment wrong");

   a_align_right: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && result.valid && !result_alignment
      |=> result_word_r == {4'h0, $past(result.data)})
      else $error("right alignment wrong");

   a_inj_hw_start: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && converter_enable && injected_trigger_edge == 2'h1 &&
      inj_sel && !inj_lvl_r |=> inj_start_r)
      else $error("injected rising trigger lost");

   a_reg_hw_start: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && converter_enable && regular_trigger_edge == 2'h2 &&
      !reg_sel && reg_lvl_r |=> reg_start_r)
      else $error("regular falling trigger lost");

   a_inj_sw_start: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && converter_enable && inj_sw_set
      |=> inj_start_r && injected_software_start_r)
      else $error("injected software start lost");

   a_reg_sw_start: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && converter_enable && reg_sw_set
      |=> reg_start_r && regular_software_start_r)
      else $error("regular software start lost");

   a_sample_code_max: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && code_c == 3'h7 |=> sample_cycles_r == 9'h1e0)
      else $error("sample code 7 not 480 cycles");

   a_low_reserved: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && bus.rd && bus.addr == `ATSC_SMP_LOW_OFS
      |=> rdata_r[31:27] == 5'h00)
      else $error("low sample reserved bits set");

   a_high_reserved: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && bus.rd && bus.addr == `ATSC_SMP_HIGH_OFS
      |=> rdata_r[31:30] == 2'h0)
      else $error("high sample reserved bits set");

   a_off_no_start: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && !converter_enable |=> !reg_start_r && !inj_start_r)
      else $error("start while disabled");

   a_trig_one_pulse: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && !reg_sw_set && regular_trigger_edge != 2'h3 &&
      reg_start_r && $stable(ctrl_r) |=> !reg_start_r)
      else $error("one edge gave two starts");

   a_sw_auto_clear: assert property (@(posedge clk)
      disable iff (!nrst)
      ce && core.reg_begun && !reg_sw_set
      |=> !regular_software_start_r)
      else $error("software start not cleared");

endmodule

// File: src/atsc_regs.svh
`ifndef ATSC_REGS_SVH
`define ATSC_REGS_SVH

// Register byte offsets
`define ATSC_STATUS_OFS 8'h00
`define ATSC_CTRL2_OFS 8'h08
`define ATSC_SMP_LOW_OFS 8'h0c
`define ATSC_SMP_HIGH_OFS 8'h10
`define ATSC_RESULT_OFS 8'h4c

// Field positions
`define ATSC_EN_BIT 0
`define ATSC_DONE_FLAG_BIT 1
`define ATSC_DONE_SEL_BIT 10
`define ATSC_ALIGN_BIT 11
`define ATSC_INJ_SRC_LSB 16
`define ATSC_INJ_EDGE_LSB 20
`define ATSC_INJ_SW_BIT 22
`define ATSC_REG_SRC_LSB 24
`define ATSC_REG_EDGE_LSB 28
`define ATSC_REG_SW_BIT 30
`define ATSC_LOW_CHANNELS 9
`define ATSC_HIGH_CHANNELS 10

// Writable bit masks and reset values
`define ATSC_CTRL_MASK 32'h3f3f_0c01
`define ATSC_SMP_LOW_MASK 32'h07ff_ffff
`define ATSC_SMP_HIGH_MASK 32'h3fff_ffff
`define ATSC_CTRL_RST 32'h0000_0000
`define ATSC_SMP_RST 32'h0000_0000

// Sample time in converter clock cycles per code
`define ATSC_SMP_CYC_0 9'h003
`define ATSC_SMP_CYC_1 9'h00f
`define ATSC_SMP_CYC_2 9'h01c
`define ATSC_SMP_CYC_3 9'h038
`define ATSC_SMP_CYC_4 9'h054
`define ATSC_SMP_CYC_5 9'h070
`define ATSC_SMP_CYC_6 9'h090
`define ATSC_SMP_CYC_7 9'h1e0

`endif

// File: src/atsc_pkg.sv
package atsc_pkg;

   // Register port request from software
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } atsc_bus_t;

   // Progress reports from the conversion core
   typedef struct packed {
      logic reg_begun;
      logic inj_begun;
      logic conv_done;
      logic seq_done;
   } atsc_core_t;

   // Raw converted sample
   typedef struct packed {
      logic valid;
      logic [11:0] data;
   } atsc_result_t;

   typedef logic [1:0] atsc_edge_t;

endpackage

// File: sim/atsc_far_model.sv
`timescale 1ns/1ps
module atsc_far_model (
   input wire logic clk,
   input wire logic reg_start,
   input wire logic inj_start,
   input wire logic [3:0] delay,
   output logic [15:0] inj_lines,
   output logic [15:0] reg_lines,
   output atsc_pkg::atsc_core_t core,
   output atsc_pkg::atsc_result_t result
);
   import atsc_pkg::*;
   logic [3:0] rcnt;
   logic [3:0] icnt;
   initial begin
      inj_lines = '0;
      reg_lines = '0;
      core = '0;
      result = '0;
      rcnt = '0;
      icnt = '0;
   end
   // Core reports a begun group after a delay
   always @(posedge clk) begin
      core.reg_begun <= (rcnt == 4'h1);
      core.inj_begun <= (icnt == 4'h1);
      rcnt <= reg_start ? delay : (rcnt != 4'h0 ? rcnt - 4'h1 : 4'h0);
      icnt <= inj_start ? delay : (icnt != 4'h0 ? icnt - 4'h1 : 4'h0);
   end
   task pulse_core(input logic conv, input logic seq);
      @(posedge clk);
      core.conv_done <= conv;
      core.seq_done <= seq;
      @(posedge clk);
      core.conv_done <= 1'b0;
      core.seq_done <= 1'b0;
   endtask
   // Data line shows a changed pattern once valid drops
   task give_result(input logic [11:0] d);
      @(posedge clk);
      result <= {1'b1, d};
      @(posedge clk);
      result <= {1'b0, ~d};
   endtask
   // Timer or interrupt line level
   task set_line(input logic inj, input logic [3:0] idx, input logic v);
      @(posedge clk);
      if (inj) begin
         inj_lines[idx] <= v;
      end else begin
         reg_lines[idx] <= v;
      end
   endtask
endmodule

// File: sim/test_adc_trigger_sample_control.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
$display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module test_adc_trigger_sample_control;
   import atsc_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   atsc_bus_t bus = '0;
   atsc_core_t core;
   atsc_result_t result;
   logic [15:0] inj_lines;
   logic [15:0] reg_lines;
   logic [4:0] sample_channel = '0;
   logic [3:0] far_delay = 4'h8;
   logic [31:0] rdata_r;
   logic converter_enable_r;
   logic reg_start_r;
   logic inj_start_r;
   logic conversion_done_flag_r;
   logic [15:0] result_word_r;
   logic [8:0] sample_cycles_r;
   int fail_count = 0;
   int checks_done = 0;
   int n_reg = 0;
   int n_inj = 0;
   logic [8:0] cyc [8] = '{9'h003, 9'h00f, 9'h01c, 9'h038, 9'h054, 9'h070,
      9'h090, 9'h1e0};

   atsc_ctrl i_atsc_ctrl (.clk(clk), .nrst(nrst), .ce(ce), .bus(bus),
      .rdata_r(rdata_r), .inj_trig_in(inj_lines), .reg_trig_in(reg_lines),
      .core(core), .result(result), .sample_channel(sample_channel),
      .converter_enable_r(converter_enable_r), .reg_start_r(reg_start_r),
      .inj_start_r(inj_start_r),
      .conversion_done_flag_r(conversion_done_flag_r),
      .result_word_r(result_word_r), .sample_cycles_r(sample_cycles_r));
   atsc_far_model i_atsc_far_model (.clk(clk), .reg_start(reg_start_r),
      .inj_start(inj_start_r), .delay(far_delay), .inj_lines(inj_lines),
      .reg_lines(reg_lines), .core(core), .result(result));

   always #4 clk = ~clk;
   // Start pulses counted mid-cycle
   always @(negedge clk) begin
      n_reg += int'(reg_start_r);
      n_inj += int'(inj_start_r);
   end

   task cyc_wait(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      `CHK(rdata_r, e)
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task t_reset;
      rchk(8'h08, 32'h0);
      rchk(8'h0c, 32'h0);
      rchk(8'h10, 32'h0);
      `CHK(sample_cycles_r, 9'h003)
   endtask
   task t_masks;
      wr(8'h0c, 32'hffff_ffff);
      rchk(8'h0c, 32'h07ff_ffff);
      wr(8'h10, 32'hffff_ffff);
      rchk(8'h10, 32'h3fff_ffff);
      wr(8'h40, 32'h1234_5678);
      rchk(8'h40, 32'h0);
   endtask
   task t_sample;
      for (int c = 0; c < 8; c++) begin
         wr(8'h0c, {5'h0, 3'(7 - c), 21'h0, 3'(c)});
         wr(8'h10, {2'h0, 3'(c), 24'h0, 3'(7 - c)});
         sample_channel <= 5'd0;
         cyc_wait(2);
         #1 `CHK(sample_cycles_r, cyc[c])
         sample_channel <= 5'd8;
         cyc_wait(2);
         #1 `CHK(sample_cycles_r, cyc[7 - c])
         sample_channel <= 5'd9;
         cyc_wait(2);
         #1 `CHK(sample_cycles_r, cyc[7 - c])
         sample_channel <= 5'd18;
         cyc_wait(2);
         #1 `CHK(sample_cycles_r, cyc[c])
      end
   endtask
   task t_trig;
      logic [3:0] s;
      int own;
      int other;
      for (int e = 0; e < 4; e++) begin
         for (int g = 0; g < 2; g++) begin
            s = 4'(e * 5);
            wr(8'h08, 32'h1 | (32'(s) << (g ? 16 : 24)) |
               (32'(e) << (g ? 20 : 28)));
            cyc_wait(4);
            n_reg = 0;
            n_inj = 0;
            i_atsc_far_model.set_line(1'(g), s ^ 4'h1, 1'b1);
            i_atsc_far_model.set_line(1'(g), s, 1'b1);
            cyc_wait(6);
            own = g ? n_inj : n_reg;
            `CHK(own, e % 2)
            i_atsc_far_model.set_line(1'(g), s, 1'b0);
            i_atsc_far_model.set_line(1'(g), s ^ 4'h1, 1'b0);
            cyc_wait(6);
            own = g ? n_inj : n_reg;
            other = g ? n_reg : n_inj;
            `CHK(own, e % 2 + e / 2)
            `CHK(other, 0)
         end
      end
      wr(8'h08, 32'h3f3f_0000);
      n_reg = 0;
      n_inj = 0;
      i_atsc_far_model.set_line(1'b0, 4'hf, 1'b1);
      i_atsc_far_model.set_line(1'b1, 4'hf, 1'b1);
      cyc_wait(6);
      i_atsc_far_model.set_line(1'b0, 4'hf, 1'b0);
      i_atsc_far_model.set_line(1'b1, 4'hf, 1'b0);
      cyc_wait(6);
      `CHK(n_reg + n_inj, 0)
      `CHK(converter_enable_r, 1'b0)
   endtask
   task t_sw;
      wr(8'h08, 32'h1);
      far_delay <= 4'h8;
      n_reg = 0;
      wr(8'h08, 32'h4000_0001);
      rchk(8'h08, 32'h4000_0001);
      `CHK(converter_enable_r, 1'b1)
      cyc_wait(12);
      rchk(8'h08, 32'h1);
      `CHK(n_reg, 1)
      far_delay <= 4'h1;
      n_inj = 0;
      wr(8'h08, 32'h0040_0001);
      cyc_wait(4);
      rchk(8'h08, 32'h1);
      `CHK(n_inj, 1)
   endtask
   task t_done;
      wr(8'h08, 32'h1);
      i_atsc_far_model.pulse_core(1'b1, 1'b0);
      #1 `CHK(conversion_done_flag_r, 1'b0)
      i_atsc_far_model.pulse_core(1'b0, 1'b1);
      #1 `CHK(conversion_done_flag_r, 1'b1)
      wr(8'h00, 32'h0);
      #1 `CHK(conversion_done_flag_r, 1'b0)
      wr(8'h08, 32'h401);
      i_atsc_far_model.pulse_core(1'b1, 1'b0);
      #1 `CHK(conversion_done_flag_r, 1'b1)
      rchk(8'h00, 32'h2);
      wr(8'h00, 32'h0);
   endtask
   task t_align;
      wr(8'h08, 32'h1);
      i_atsc_far_model.give_result(12'habc);
      #1 `CHK(result_word_r, 16'h0abc)
      wr(8'h08, 32'h801);
      i_atsc_far_model.give_result(12'h5a3);
      #1 `CHK(result_word_r, 16'h5a30)
      rchk(8'h4c, 32'h0000_5a30);
   endtask
   // Writes while the clock enable is low must be ignored
   task t_ce;
      n_reg = 0;
      @(posedge clk);
      ce <= 1'b0;
      wr(8'h0c, 32'h0700_0000);
      wr(8'h08, 32'h4000_0001);
      @(posedge clk);
      ce <= 1'b1;
      rchk(8'h0c, 32'h0000_0007);
      rchk(8'h08, 32'h0000_0801);
      `CHK(n_reg, 0)
   endtask

   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_masks();
      t_sample();
      t_trig();
      t_sw();
      t_done();
      t_align();
      t_ce();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      print_verdict();
   end
endmodule
